/* ddr_b2_sram_end.sv */
// Purpose: sram end of a double data rate burst-of-two link
// Assumes: k_true marks each true clock rising edge, the next cycle the complement edge
// Notes: storage is two arrays, one per burst word; memory has no reset
//   read data leaves one edge after the load; the longer pin latency is not modelled
//   a write burst that overlaps read data is for the controller to avoid
`timescale 1ns/1ns
module ddr_b2_sram_end (
  input wire logic i_mclk,
  input wire logic i_nrst,
  ddr_b2_if.dev link
);
  import ddr_b2_pkg::*;

  // two arrays, one per word of the burst
  // no reset on the arrays: clearing 2 x 256K words costs far more than it buys
  logic [DATA_W-1:0] mem_first [DEPTH];
  logic [DATA_W-1:0] mem_second [DEPTH];

  dev_state_t state_q;
  dev_state_t state_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] dout_d;
  logic oe_q;
  logic oe_d;

  // edge decoding
  wire true_edge;
  wire comp_edge;
  wire load;
  wire new_rd;
  wire new_wr;
  wire second_wr;
  wire second_rd;

  // only a true edge may open an access
  assign true_edge = link.k_true;
  assign comp_edge = ~link.k_true;
  // strobe low on a true edge defines a transaction
  assign load = true_edge & ~link.load_strobe_n;
  // direction is read from the select only while loading
  assign new_rd = load & (link.read_write_select == RW_READ);
  assign new_wr = load & (link.read_write_select == RW_WRITE);
  // second word of the burst follows on the complement edge
  assign second_wr = comp_edge & (state_q == DEV_WR2);
  assign second_rd = comp_edge & (state_q == DEV_RD2);

  // per-array strobes: the first array only moves on a true edge,
  // the second only on the complement edge right after its load
  wire wr_first;
  wire wr_second;
  wire rd_first;
  wire rd_second;
  wire wr_any;
  wire [ADDR_W-1:0] addr_first;
  wire [ADDR_W-1:0] addr_second;
  wire [DATA_W-1:0] word_first;
  wire [DATA_W-1:0] word_second;

  assign wr_first = new_wr;
  assign wr_second = second_wr;
  assign rd_first = new_rd;
  assign rd_second = second_rd;
  assign wr_any = wr_first | wr_second;
  // one address bus serves both directions; the first word uses the pins,
  // the second the latched copy, so the bus may already carry the next one
  assign addr_first = link.addr;
  assign addr_second = addr_q;
  assign word_first = mem_first[addr_first];
  assign word_second = mem_second[addr_second];

  // write merge path
  wire [DATA_W-1:0] old_word;
  wire [DATA_W-1:0] merged;
  wire [LANES-1:0] lane_sel_n;

  // old contents of the array that this edge owns
  assign old_word = true_edge ? word_first : word_second;
  // the select seen with each word qualifies that word alone; outside a
  // write no lane is opened, so a stray select cannot reach the arrays
  assign lane_sel_n = wr_any ? link.byte_lane_write_n : LANES_OFF_N;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      // lane g owns bits 9g+8..9g
      lane_merge #(
        .W(LANE_W)
      ) u_lane (
        .i_old(old_word[g*LANE_W +: LANE_W]),
        .i_new(link.dq_i[g*LANE_W +: LANE_W]),
        .i_sel_n(lane_sel_n[g]),
        .o_word(merged[g*LANE_W +: LANE_W])
      );
    end
  endgenerate

  // array writes: first word on the true edge, second on the complement
  always_ff @(posedge i_mclk) begin
    if (wr_first) begin
      mem_first[addr_first] <= merged;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (wr_second) begin
      mem_second[addr_second] <= merged;
    end
  end

  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      DEV_IDLE: begin
        state_d = DEV_IDLE;
      end
      DEV_WR2: begin
        state_d = DEV_IDLE;
      end
      DEV_RD2: begin
        state_d = DEV_IDLE;
      end
      default: begin
        state_d = DEV_IDLE;
      end
    endcase
    // a new load overrides whatever the last cycle left; a burst never
    // spans two true edges, so nothing is cut short by it
    if (new_wr) begin
      state_d = DEV_WR2;
    end else if (new_rd) begin
      state_d = DEV_RD2;
    end
  end

  // address is latched only when an access is defined
  assign addr_d = load ? link.addr : addr_q;

  // read launch: first word on the true edge, second on the complement
  always_comb begin
    dout_d = dout_q;
    oe_d = oe_q;
    if (rd_first) begin
      dout_d = word_first;
      oe_d = 1'b1;
    end else if (rd_second) begin
      dout_d = word_second;
      oe_d = 1'b1;
    end else if (true_edge) begin
      // no read on this true edge: release the pins, no enable pin needed
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= DEV_IDLE;
      addr_q <= ADDR_ZERO;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
    end
  end

  // the word flops keep the last word while released; only the enable says it is driven
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      dout_q <= DATA_ZERO;
    end else begin
      dout_q <= dout_d;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  // pins straight from flops
  assign link.d_dq_o = dout_q;
  assign link.d_dq_oe = oe_q;

  // the pins hold strobe high on idle true edges, so the
  // idle branch above is the normal deselected cycle
endmodule

/* ddr_b2_pkg.sv */
// Purpose: shared constants and state types for the burst-of-two ddr sram link
// Assumes: wide variant, one system clock, ddr edges shown as alternate clock phases
// Notes: a k_true cycle stands for a true clock rising edge, the other cycle for the complement
package ddr_b2_pkg;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int NARROW_LANES = 2;
  localparam int ADDR_W = 18;
  localparam int DEPTH = 262144;
  localparam int BURST_LEN = 2;
  localparam int CLK_MHZ = 25;
  localparam logic RW_READ = 1'h1;
  localparam logic RW_WRITE = 1'h0;
  localparam logic [LANES-1:0] LANES_OFF_N = 4'hf;
  localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h0;
  localparam logic [2:0] RD_PIPE_ZERO = 3'h0;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_WR2 = 3'b010,
    DEV_RD2 = 3'b100
  } dev_state_t;

  typedef enum logic [2:0] {
    CT_IDLE = 3'b001,
    CT_WORD0 = 3'b010,
    CT_WORD1 = 3'b100
  } ctrl_state_t;
endpackage

/* ddr_b2_if.sv */
// Purpose: pins between the memory controller and the burst-of-two sram
// Assumes: both ends run on the same system clock
// Notes: the shared data pins are resolved here from the two output enables
`timescale 1ns/1ns
interface ddr_b2_if;
  import ddr_b2_pkg::*;
  logic k_true;
  logic load_strobe_n;
  logic read_write_select;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] byte_lane_write_n;
  logic [DATA_W-1:0] c_dq_o;
  logic c_dq_oe;
  logic [DATA_W-1:0] d_dq_o;
  logic d_dq_oe;
  logic [DATA_W-1:0] dq_i;

  // one resolved value, no floating level; a clash is flagged by the link checker
  assign dq_i = d_dq_oe ? d_dq_o : (c_dq_oe ? c_dq_o : DATA_ZERO);

  modport ctrl (
    output k_true,
    output load_strobe_n,
    output read_write_select,
    output addr,
    output byte_lane_write_n,
    output c_dq_o,
    output c_dq_oe,
    input dq_i
  );

  modport dev (
    input k_true,
    input load_strobe_n,
    input read_write_select,
    input addr,
    input byte_lane_write_n,
    output d_dq_o,
    output d_dq_oe,
    input dq_i
  );
endinterface

/* lane_merge.sv */
// Purpose: one byte lane of a masked write
// Assumes: select is active low
// Notes: a deselected lane keeps the stored bits
`timescale 1ns/1ns
module lane_merge #(
  parameter int W = 9
) (
  input wire logic [W-1:0] i_old,
  input wire logic [W-1:0] i_new,
  input wire logic i_sel_n,
  output logic [W-1:0] o_word
);
  assign o_word = i_sel_n ? i_old : i_new;
endmodule

/* ddr_b2_ctrl_end.sv */
// Purpose: memory controller end of the burst-of-two ddr sram link
// Assumes: one request per true edge slot; user holds request until taken
// Notes: a write is refused in the slot right after a read to avoid a bus clash
`timescale 1ns/1ns
module ddr_b2_ctrl_end (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic i_rw,
  input wire logic [ddr_b2_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ddr_b2_pkg::DATA_W-1:0] i_wdata0,
  input wire logic [ddr_b2_pkg::DATA_W-1:0] i_wdata1,
  input wire logic [ddr_b2_pkg::LANES-1:0] i_lane_wr_n0,
  input wire logic [ddr_b2_pkg::LANES-1:0] i_lane_wr_n1,
  output logic o_rd_ready,
  output logic o_wr_ready,
  output logic [ddr_b2_pkg::DATA_W-1:0] o_rdata0,
  output logic [ddr_b2_pkg::DATA_W-1:0] o_rdata1,
  output logic o_rvalid,
  ddr_b2_if.ctrl link
);
  import ddr_b2_pkg::*;

  ctrl_state_t state_q;
  logic phase_q;
  logic rd_ready_q;
  logic wr_ready_q;
  logic [2:0] rd_pipe_q;
  logic strobe_n_q;
  logic rw_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] dq_o_q;
  logic dq_oe_q;
  logic [LANES-1:0] lanes_n_q;
  logic [DATA_W-1:0] wdata1_q;
  logic [LANES-1:0] mask1_q;
  logic [DATA_W-1:0] rdata0_q;
  logic [DATA_W-1:0] rdata1_q;
  logic rvalid_q;

  // a take happens at the end of a complement-phase cycle, so loads meet a true edge
  wire take_rd;
  wire take_wr;
  assign take_rd = ~phase_q & i_req & (i_rw == RW_READ) & rd_ready_q;
  assign take_wr = ~phase_q & i_req & (i_rw == RW_WRITE) & wr_ready_q;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase_q <= 1'b0;
      rd_ready_q <= 1'b0;
      wr_ready_q <= 1'b0;
      rd_pipe_q <= RD_PIPE_ZERO;
    end else begin
      phase_q <= ~phase_q;
      rd_ready_q <= phase_q;
      // write words would collide with the read words of the previous slot
      wr_ready_q <= phase_q & ~rd_pipe_q[0];
      rd_pipe_q <= {rd_pipe_q[1:0], take_rd};
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= CT_IDLE;
      strobe_n_q <= 1'b1;
      rw_q <= RW_READ;
      addr_q <= ADDR_ZERO;
      dq_o_q <= DATA_ZERO;
      dq_oe_q <= 1'b0;
      lanes_n_q <= LANES_OFF_N;
      wdata1_q <= DATA_ZERO;
      mask1_q <= LANES_OFF_N;
    end else if (take_rd | take_wr) begin
      state_q <= take_wr ? CT_WORD0 : CT_IDLE;
      strobe_n_q <= 1'b0;
      rw_q <= i_rw;
      addr_q <= i_addr;
      dq_o_q <= i_wdata0;
      dq_oe_q <= take_wr;
      lanes_n_q <= take_wr ? i_lane_wr_n0 : LANES_OFF_N;
      wdata1_q <= i_wdata1;
      mask1_q <= i_lane_wr_n1;
    end else begin
      // idle true edges see the strobe high
      strobe_n_q <= 1'b1;
      case (state_q)
        CT_WORD0: begin
          state_q <= CT_WORD1;
          dq_o_q <= wdata1_q;
          lanes_n_q <= mask1_q;
        end
        CT_WORD1: begin
          state_q <= CT_IDLE;
          dq_oe_q <= 1'b0;
          lanes_n_q <= LANES_OFF_N;
        end
        default: begin
          state_q <= CT_IDLE;
          dq_oe_q <= 1'b0;
          lanes_n_q <= LANES_OFF_N;
        end
      endcase
    end
  end

  // read words arrive one and two cycles after the loading cycle
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata0_q <= DATA_ZERO;
      rdata1_q <= DATA_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      if (rd_pipe_q[1]) begin
        rdata0_q <= link.dq_i;
      end
      if (rd_pipe_q[2]) begin
        rdata1_q <= link.dq_i;
      end
      rvalid_q <= rd_pipe_q[2];
    end
  end

  assign link.k_true = phase_q;
  assign link.load_strobe_n = strobe_n_q;
  assign link.read_write_select = rw_q;
  assign link.addr = addr_q;
  assign link.byte_lane_write_n = lanes_n_q;
  assign link.c_dq_o = dq_o_q;
  assign link.c_dq_oe = dq_oe_q;
  assign o_rd_ready = rd_ready_q;
  assign o_wr_ready = wr_ready_q;
  assign o_rdata0 = rdata0_q;
  assign o_rdata1 = rdata1_q;
  assign o_rvalid = rvalid_q;
endmodule

/* ddr_b2_link_props.sv */
// Purpose: assertions on the pins between the two ends of the sram link
// Assumes: one clock domain, reset active low
// Notes: watches only what the two ends drive onto the link
`timescale 1ns/1ns
module ddr_b2_link_props (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic k_true,
  input wire logic load_strobe_n,
  input wire logic read_write_select,
  input wire logic [ddr_b2_pkg::LANES-1:0] byte_lane_write_n,
  input wire logic c_dq_oe,
  input wire logic d_dq_oe
);
  import ddr_b2_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  wire rd_load = !load_strobe_n && read_write_select == RW_READ;
  wire wr_load = !load_strobe_n && read_write_select == RW_WRITE;

  property p_load_true; !load_strobe_n |-> k_true; endproperty
  a_load_true: assert property (p_load_true)
    else $error("load strobe off a true edge");
  // the marker stands still in reset, so the first edge after release is skipped
  property p_k_toggle; $past(i_nrst) |-> k_true != $past(k_true); endproperty
  a_k_toggle: assert property (p_k_toggle)
    else $error("true edge marker did not alternate");
  property p_rd_drive; rd_load |=> d_dq_oe [*2]; endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("read burst not driven for two words");
  // a read keeps the pins at most two cycles after its load
  property p_rd_release; d_dq_oe |-> $past(rd_load) || $past(rd_load, 2); endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("sram drives pins with no read selected");
  property p_wr_drive; wr_load |-> c_dq_oe && !d_dq_oe ##1 c_dq_oe; endproperty
  a_wr_drive: assert property (p_wr_drive)
    else $error("write burst data not presented on both edges");
  property p_no_clash; !(c_dq_oe && d_dq_oe); endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data pins");
  property p_lanes_idle; !c_dq_oe |-> byte_lane_write_n == LANES_OFF_N; endproperty
  a_lanes_idle: assert property (p_lanes_idle)
    else $error("lane select active without write data");
  property p_rd_quiet; rd_load |-> !c_dq_oe [*3]; endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("controller drives pins during a read");

  c_wr: cover property (wr_load);
  c_rd: cover property (rd_load);
  c_wr_wr: cover property (wr_load ##2 wr_load);
  c_wr_rd: cover property (wr_load ##2 rd_load);
endmodule

/* ddr_burst2_sram_port_test.sv */
// Purpose: self-checking bench for the controller and sram ends joined back to back
// Assumes: user port driven on the falling edge, one request held until taken
// Notes: expected data comes from a bench-side lane merge, never from the design
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module ddr_burst2_sram_port_test;
  import ddr_b2_pkg::*;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_req = 1'b0;
  logic i_rw = 1'b0;
  logic [ADDR_W-1:0] i_addr = ADDR_ZERO;
  logic [DATA_W-1:0] i_wdata0 = DATA_ZERO;
  logic [DATA_W-1:0] i_wdata1 = DATA_ZERO;
  logic [LANES-1:0] i_lane_wr_n0 = LANES_OFF_N;
  logic [LANES-1:0] i_lane_wr_n1 = LANES_OFF_N;
  logic o_rd_ready, o_wr_ready, o_rvalid;
  logic [DATA_W-1:0] o_rdata0, o_rdata1, e0, e1;
  logic [LANES-1:0] m;
  int err_count = 0;
  int checks_done = 0;

  ddr_b2_if i_ddr_b2_if();
  ddr_b2_ctrl_end i_ddr_b2_ctrl_end (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req(i_req),
    .i_rw(i_rw), .i_addr(i_addr), .i_wdata0(i_wdata0), .i_wdata1(i_wdata1),
    .i_lane_wr_n0(i_lane_wr_n0), .i_lane_wr_n1(i_lane_wr_n1), .o_rd_ready(o_rd_ready),
    .o_wr_ready(o_wr_ready), .o_rdata0(o_rdata0), .o_rdata1(o_rdata1),
    .o_rvalid(o_rvalid), .link(i_ddr_b2_if.ctrl));
  ddr_b2_sram_end i_ddr_b2_sram_end (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .link(i_ddr_b2_if.dev));
  ddr_b2_link_props i_ddr_b2_link_props (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .k_true(i_ddr_b2_if.k_true), .load_strobe_n(i_ddr_b2_if.load_strobe_n),
    .read_write_select(i_ddr_b2_if.read_write_select),
    .byte_lane_write_n(i_ddr_b2_if.byte_lane_write_n),
    .c_dq_oe(i_ddr_b2_if.c_dq_oe), .d_dq_oe(i_ddr_b2_if.d_dq_oe));

  always #20 i_mclk = ~i_mclk;

  function automatic logic [DATA_W-1:0] mrg(input logic [DATA_W-1:0] o, n,
    input logic [LANES-1:0] s);
    mrg = o;
    for (int l = 0; l < LANES; l++) begin
      if (!s[l]) mrg[LANE_W*l +: LANE_W] = n[LANE_W*l +: LANE_W];
    end
  endfunction

  // one request, held until a ready slot passes, then dropped
  task automatic go(input logic rw, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d0, d1, input logic [LANES-1:0] s0, s1);
    int n;
    n = 0;
    @(negedge i_mclk);
    i_req = 1'b1;
    i_rw = rw;
    i_addr = a;
    i_wdata0 = d0;
    i_wdata1 = d1;
    i_lane_wr_n0 = s0;
    i_lane_wr_n1 = s1;
    while (((rw == RW_READ) ? o_rd_ready : o_wr_ready) !== 1'b1 && n < 20) begin
      @(negedge i_mclk);
      n++;
    end
    `CHK("request taken", 1'b1, n < 20)
    @(negedge i_mclk);
    i_req = 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
    input logic [LANES-1:0] s0, s1);
    go(RW_WRITE, a, d0, d1, s0, s1);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x0, x1);
    int n;
    n = 1;
    go(RW_READ, a, DATA_ZERO, DATA_ZERO, LANES_OFF_N, LANES_OFF_N);
    // next slot: another read may follow, a write must wait for the turnaround
    @(negedge i_mclk);
    `CHK("read ready after read", 1'b1, o_rd_ready)
    `CHK("write ready after read", 1'b0, o_wr_ready)
    while (o_rvalid !== 1'b1 && n < 10) begin
      @(negedge i_mclk);
      n++;
    end
    `CHK("read valid", 1'b1, o_rvalid)
    `CHK("read word0", x0, o_rdata0)
    `CHK("read word1", x1, o_rdata1)
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #(40 * 3000);
    err_count++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk);
    i_nrst = 1'b1;
    // back-to-back writes at both ends of the address range, then reads
    wr(ADDR_ZERO, 36'h123456789, 36'h9abcdef01, 4'h0, 4'h0);
    wr(18'h3ffff, 36'h0a5a5a5a5, 36'hf0f0f0f0f, 4'h0, 4'h0);
    rd(ADDR_ZERO, 36'h123456789, 36'h9abcdef01);
    rd(18'h3ffff, 36'h0a5a5a5a5, 36'hf0f0f0f0f);
    $display("test burst done");
    // each word has its own lane selects
    wr(18'h3ffff, 36'h876543210, 36'h13579bdf0, 4'h5, 4'ha);
    e0 = mrg(36'h0a5a5a5a5, 36'h876543210, 4'h5);
    e1 = mrg(36'hf0f0f0f0f, 36'h13579bdf0, 4'ha);
    rd(18'h3ffff, e0, e1);
    rd(ADDR_ZERO, 36'h123456789, 36'h9abcdef01);
    $display("test lane mask done");
    // one lane at a time; word1 fully deselected stays zero
    wr(18'h00005, DATA_ZERO, DATA_ZERO, 4'h0, 4'h0);
    e0 = DATA_ZERO;
    for (int i = 0; i < LANES; i++) begin
      m = LANES_OFF_N ^ (4'h1 << i);
      wr(18'h00005, {DATA_W{1'b1}}, {DATA_W{1'b1}}, m, LANES_OFF_N);
      e0 = e0 | (36'h1ff << (LANE_W * i));
      rd(18'h00005, e0, DATA_ZERO);
    end
    $display("test lane walk done");
    close_out();
  end
endmodule
